// ### inc/lcflg_map.vh
// Bit positions, masks and reset values of the legacy control flag register.
`ifndef LCFLG_MAP_VH
`define LCFLG_MAP_VH
`define LCFLG_PROT_MODE 0
`define LCFLG_COPRO_MON 1
`define LCFLG_FP_TRAP_ALL 2
`define LCFLG_TASK_SW 3
`define LCFLG_EXT_TYPE 4
`define LCFLG_NUM_ERR 5
`define LCFLG_PORT_CHECK 6
`define LCFLG_INT_GATE 7
`define LCFLG_INT_ICPT 8
`define LCFLG_WRITE_PROT 16
`define LCFLG_ALIGN_MASK 18
`define LCFLG_NO_WT 29
`define LCFLG_CACHE_DIS 30
`define LCFLG_RESV_MASK 64'hfffff80000000000
`define LCFLG_LEGACY_RD_ZERO 32'h000001c0
`define LCFLG_EXT_TYPE_SET 64'h0000000000000010
`define LCFLG_RESET 64'h0000000000000010
`define LCFLG_EFL_RESET 32'h00000002
`define LCFLG_EFL_INT 9
`define LCFLG_EFL_IOPL_LO 12
`define LCFLG_EFL_ALIGN 18
`define LCFLG_EFL_FEATURE 21
`define LCFLG_EFL_WMASK 32'h00247fd5
`define LCFLG_USER_PL 2'h3
`endif

// ### core/lcflg_regs.v
// Legacy control flag register with its legacy-execution decode.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Read any level; write only at level 0.
// - Non-zero reserved bits fault the write.
// - Legacy move-to intercepts; move-from returns low half.
// - Low-half writes store only, no flush.
// - Bit 0 selects legacy protected mode only.
// - Monitor and task-switched fault the wait op.
// - Trap-all faults float; packed ops intercept.
// - Task-switched faults float and packed ops.
// - Extension type bit ignored, reads one.
// - Numeric errors always on, error pin idle.
// - Port check with privilege above level uses bitmap.
// - Bits 6 to 8 read zero legacy.
// - Interrupts need enable, plus the flag when gated.
// - Intercept bit traps interrupt flag changes by clear, set and pop ops only.
// - Write-protect bit is storage only.
// - Alignment fault from native check or mask.
// - Cache bits are storage only.
// - Feature query bit legacy-writable and readable.
// - Flags word never steers native execution.
// - Legacy system register accesses are intercepted.
// - Interrupt flag writes ignored above port level.
////////////////////////////////////////////////////////////////////////////////
`include "lcflg_map.vh"

module lcflg_regs
(
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	// Native application register access.
	input wire nat_wr,
	input wire [63:0] nat_wdata,
	input wire [1:0] cur_priv,
	output reg [63:0] nat_rdata,
	output reg priv_reg_fault,
	output reg resv_field_fault,
	// Legacy instruction attempt and its class, one cycle each.
	input wire leg_valid,
	input wire leg_mov_to_cr0,
	input wire leg_mov_from_cr0,
	input wire leg_sys_reg_op,
	input wire leg_wait_op,
	input wire leg_fp_op,
	input wire leg_packed_op,
	input wire leg_port_op,
	input wire leg_unaligned,
	input wire [1:0] leg_eff_priv,
	input wire leg_clear_int_flag_op,
	input wire leg_set_int_flag_op,
	input wire leg_pop_flags_op,
	input wire leg_flags_wr,
	input wire [31:0] leg_flags_wdata,
	input wire native_int_enable,
	input wire native_align_check,
	input wire fp_error_ignore_in,
	output reg [31:0] leg_rdata,
	output reg [31:0] legacy_flags_word,
	output reg intercept_fault,
	output reg coprocessor_unavailable_fault,
	output reg align_check_fault,
	output reg sys_flag_trap,
	output reg port_bitmap_consult,
	output reg protected_mode,
	output reg ext_int_enable,
	output reg fp_error_out
);

	////////////////////////////////////////////////////////////////////////
	// Stored state.
	reg [63:0] legacy_control_flags; // The 64-bit control flag register.
	reg [63:0] next_flags; // Value after an accepted native write.
	reg [31:0] next_eflags; // Legacy flags word after this cycle.
	reg nat_wr_ok; // Native write accepted this cycle.
	reg cur_above_iopl; // Current privilege exceeds the port level.
	reg int_flag_changed; // A clear, set or pop op changed the interrupt flag.
	reg next_int_fault_cp; // Coprocessor-unavailable decision.
	reg next_int_icpt; // Instruction intercept decision.
	reg [31:0] masked_wdata; // Legacy flags write after privilege masking.
	wire [1:0] iopl;

	assign iopl = legacy_flags_word[`LCFLG_EFL_IOPL_LO+1:`LCFLG_EFL_IOPL_LO];

	////////////////////////////////////////////////////////////////////////
	// Combinational decode of the current register and the requests.
	// Decisions read the stored value, so a completed write governs the
	// very next legacy instruction.
	always @*
	begin
		nat_wr_ok = nat_wr && (cur_priv == 2'h0) &&
			((nat_wdata & `LCFLG_RESV_MASK) == 64'h0);
		// Extension type bit forced to one; other bits stored as written,
		// ignored ranges included, with no flush side effect.
		next_flags = nat_wdata | `LCFLG_EXT_TYPE_SET;
		cur_above_iopl = cur_priv > iopl;
		masked_wdata = leg_flags_wdata;
		// Interrupt flag writes above the port level are dropped.
		if (cur_above_iopl)
		begin
			masked_wdata[`LCFLG_EFL_INT] = legacy_flags_word[`LCFLG_EFL_INT];
		end
		// Port level itself changes only at privilege zero.
		if (cur_priv != 2'h0)
		begin
			masked_wdata[`LCFLG_EFL_IOPL_LO+1:`LCFLG_EFL_IOPL_LO] = iopl;
		end
		next_eflags = legacy_flags_word;
		if (leg_valid && leg_clear_int_flag_op && !cur_above_iopl)
		begin
			next_eflags[`LCFLG_EFL_INT] = 1'b0;
		end
		else if (leg_valid && leg_set_int_flag_op && !cur_above_iopl)
		begin
			next_eflags[`LCFLG_EFL_INT] = 1'b1;
		end
		else if (leg_valid && (leg_flags_wr || leg_pop_flags_op))
		begin
			// Feature query bit is in the writable mask.
			next_eflags = (legacy_flags_word & ~`LCFLG_EFL_WMASK) |
				(masked_wdata & `LCFLG_EFL_WMASK);
		end
		int_flag_changed = (leg_clear_int_flag_op || leg_set_int_flag_op ||
			leg_pop_flags_op) && (next_eflags[`LCFLG_EFL_INT] !=
			legacy_flags_word[`LCFLG_EFL_INT]);
		// Task switched blocks float and packed ops; trap-all blocks
		// float ops and wait needs monitor plus task switched.
		next_int_fault_cp = (leg_wait_op &&
			legacy_control_flags[`LCFLG_COPRO_MON] &&
			legacy_control_flags[`LCFLG_TASK_SW]) ||
			((leg_fp_op || leg_packed_op) &&
			legacy_control_flags[`LCFLG_TASK_SW]) ||
			(leg_fp_op && legacy_control_flags[`LCFLG_FP_TRAP_ALL]);
		// Packed ops under trap-all intercept unless a coprocessor fault
		// already takes priority.
		next_int_icpt = leg_mov_to_cr0 || leg_sys_reg_op ||
			(leg_packed_op && legacy_control_flags[`LCFLG_FP_TRAP_ALL] &&
			!legacy_control_flags[`LCFLG_TASK_SW]);
	end

	////////////////////////////////////////////////////////////////////////
	// Register and output flops; everything holds while clk_en is low.
	// Outputs are registered so every decision appears one cycle later.
	always @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			legacy_control_flags <= `LCFLG_RESET;
			legacy_flags_word <= `LCFLG_EFL_RESET;
			nat_rdata <= `LCFLG_RESET;
			leg_rdata <= 32'h0;
			priv_reg_fault <= 1'b0;
			resv_field_fault <= 1'b0;
			intercept_fault <= 1'b0;
			coprocessor_unavailable_fault <= 1'b0;
			align_check_fault <= 1'b0;
			sys_flag_trap <= 1'b0;
			port_bitmap_consult <= 1'b0;
			protected_mode <= 1'b0;
			ext_int_enable <= 1'b0;
			fp_error_out <= 1'b0;
		end
		else if (clk_en)
		begin
			if (nat_wr_ok)
			begin
				legacy_control_flags <= next_flags;
			end
			legacy_flags_word <= next_eflags;
			// Native read at any level sees the stored word.
			nat_rdata <= nat_wr_ok ? next_flags : legacy_control_flags;
			priv_reg_fault <= nat_wr && (cur_priv != 2'h0);
			// Privilege fault alone is reported when both apply.
			resv_field_fault <= nat_wr && (cur_priv == 2'h0) &&
				((nat_wdata & `LCFLG_RESV_MASK) != 64'h0);
			if (leg_valid && leg_mov_from_cr0)
			begin
				leg_rdata <= legacy_control_flags[31:0] &
					~`LCFLG_LEGACY_RD_ZERO;
			end
			intercept_fault <= leg_valid && next_int_icpt;
			coprocessor_unavailable_fault <= leg_valid && next_int_fault_cp;
			align_check_fault <= leg_valid && leg_unaligned &&
				(native_align_check ||
				(legacy_control_flags[`LCFLG_ALIGN_MASK] &&
				legacy_flags_word[`LCFLG_EFL_ALIGN] &&
				leg_eff_priv == `LCFLG_USER_PL));
			sys_flag_trap <= leg_valid && int_flag_changed &&
				legacy_control_flags[`LCFLG_INT_ICPT];
			port_bitmap_consult <= leg_valid && leg_port_op &&
				legacy_control_flags[`LCFLG_PORT_CHECK] &&
				cur_above_iopl;
			// Mode select is exported for legacy decode only.
			protected_mode <= legacy_control_flags[`LCFLG_PROT_MODE];
			ext_int_enable <= native_int_enable &&
				(!legacy_control_flags[`LCFLG_INT_GATE] ||
				legacy_flags_word[`LCFLG_EFL_INT]);
			// Numeric errors stay enabled; the ignore input and the
			// numeric error bit have no say in this output.
			fp_error_out <= 1'b0 & fp_error_ignore_in;
		end
	end

endmodule // lcflg_regs
`default_nettype wire

// ### sim/lcflg_regs_properties.sv
// Port checks for the legacy control flag register.
`timescale 1ns/100ps
`default_nettype none
module lcflg_regs_properties
(
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	input wire nat_wr,
	input wire [63:0] nat_wdata,
	input wire [1:0] cur_priv,
	input wire [63:0] nat_rdata,
	input wire priv_reg_fault,
	input wire resv_field_fault,
	input wire leg_valid,
	input wire leg_mov_to_cr0,
	input wire leg_mov_from_cr0,
	input wire leg_wait_op,
	input wire [31:0] leg_rdata,
	input wire intercept_fault,
	input wire coprocessor_unavailable_fault,
	input wire fp_error_out
);
	// One clock domain, so reset masks every check at once.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Requests count only on enabled edges.
	sequence s_wr;
		clk_en && nat_wr;
	endsequence
	sequence s_leg;
		clk_en && leg_valid;
	endsequence
	property p_priv;
		s_wr ##0 cur_priv != 2'h0 |=> priv_reg_fault && $stable(nat_rdata);
	endproperty
	property p_resv;
		s_wr ##0 (cur_priv == 2'h0 && |nat_wdata[63:43])
			|=> resv_field_fault && !priv_reg_fault;
	endproperty
	property p_store;
		s_wr ##0 (cur_priv == 2'h0 && nat_wdata[63:43] == 21'h0)
			|=> nat_rdata == ($past(nat_wdata) | 64'h10);
	endproperty
	property p_mto;
		s_leg ##0 leg_mov_to_cr0 |=> intercept_fault;
	endproperty
	// Bits 6 to 8 are hidden from the legacy read.
	property p_mfrom;
		s_leg ##0 leg_mov_from_cr0
			|=> leg_rdata == (32'hfffffe3f & $past(nat_rdata));
	endproperty
	property p_wait;
		s_leg ##0 (leg_wait_op && nat_rdata[1] && nat_rdata[3])
			|=> coprocessor_unavailable_fault;
	endproperty
	property p_et;
		nat_rdata[4];
	endproperty
	property p_fperr;
		!fp_error_out;
	endproperty
	a_priv: assert property (p_priv) else $error("no privilege fault");
	a_resv: assert property (p_resv) else $error("no reserved fault");
	a_store: assert property (p_store) else $error("bad store");
	a_mto: assert property (p_mto) else $error("no intercept");
	a_mfrom: assert property (p_mfrom) else $error("bad read");
	a_wait: assert property (p_wait) else $error("no wait fault");
	a_et: assert property (p_et) else $error("type bit low");
	a_fperr: assert property (p_fperr) else $error("error pin set");
endmodule // lcflg_regs_properties
bind lcflg_regs lcflg_regs_properties lcflg_regs_properties_inst (.ref_clk,
	.resetn, .clk_en, .nat_wr, .nat_wdata, .cur_priv, .nat_rdata,
	.priv_reg_fault, .resv_field_fault, .leg_valid, .leg_mov_to_cr0,
	.leg_mov_from_cr0, .leg_wait_op, .leg_rdata, .intercept_fault,
	.coprocessor_unavailable_fault, .fp_error_out);
`default_nettype wire

// ### sim/lcflg_regs_bench.sv
// Directed bench for the legacy control flag register.
`timescale 1ns/100ps
`default_nettype none
module lcflg_regs_bench;
	reg ref_clk = 1'b0;
	reg resetn = 1'b0;
	reg clk_en = 1'b1;
	reg nat_wr = 1'b0;
	reg [63:0] nat_wdata = 64'h0;
	reg [1:0] cur_priv = 2'h0;
	reg leg_valid = 1'b0;
	reg [10:0] op = 11'h0; // One-hot legacy class.
	reg [31:0] flags_wdata = 32'h0; // Legacy flags write data.
	reg [1:0] eff_priv = 2'h0; // Effective privilege of a data access.
	reg native_int_enable = 1'b1;
	reg native_align_check = 1'b1;
	reg fp_error_ignore_in = 1'b1; // Must have no effect.
	integer n_errors = 0;
	integer checks_done = 0;
	wire [63:0] nat_rdata;
	wire [31:0] leg_rdata, legacy_flags_word;
	wire priv_reg_fault, resv_field_fault, intercept_fault, fp_error_out;
	wire coprocessor_unavailable_fault, align_check_fault;
	wire sys_flag_trap, ext_int_enable;
	wire port_bitmap_consult, protected_mode;
	lcflg_regs lcflg_regs_inst
	(
		.ref_clk, .resetn, .clk_en, .nat_wr, .nat_wdata, .cur_priv,
		.nat_rdata, .priv_reg_fault, .resv_field_fault, .leg_valid,
		.leg_mov_to_cr0(op[0]), .leg_mov_from_cr0(op[1]),
		.leg_sys_reg_op(op[9]), .leg_wait_op(op[2]), .leg_fp_op(op[3]),
		.leg_packed_op(op[4]), .leg_port_op(op[10]), .leg_unaligned(op[5]),
		.leg_eff_priv(eff_priv), .leg_clear_int_flag_op(op[6]),
		.leg_set_int_flag_op(op[7]), .leg_pop_flags_op(1'b0),
		.leg_flags_wr(op[8]), .leg_flags_wdata(flags_wdata),
		.native_int_enable, .native_align_check, .fp_error_ignore_in,
		.leg_rdata, .legacy_flags_word, .intercept_fault,
		.coprocessor_unavailable_fault, .align_check_fault, .sys_flag_trap,
		.port_bitmap_consult, .protected_mode, .ext_int_enable,
		.fp_error_out
	);
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////
	task chk(input [63:0] got, input [63:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Requests rise and fall at falling edges, answers are read a cycle on.
	task wr(input [63:0] d, input [1:0] p);
		@(negedge ref_clk);
		nat_wr = 1'b1;
		nat_wdata = d;
		cur_priv = p;
		@(negedge ref_clk);
		nat_wr = 1'b0;
	endtask
	task leg(input [10:0] o);
		@(negedge ref_clk);
		leg_valid = 1'b1;
		op = o;
		@(negedge ref_clk);
		leg_valid = 1'b0;
		op = 11'h0;
	endtask
	task summarize;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// The sequence needs well under a microsecond.
	initial
	begin
		#20000;
		n_errors = n_errors + 1;
		summarize;
	end
	initial
	begin
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		wr(64'h1, 2'h1);
		chk({resv_field_fault, priv_reg_fault}, 2'h1);
		wr(64'h80000000000, 2'h0);
		chk({resv_field_fault, priv_reg_fault}, 2'h2);
		chk(nat_rdata, 64'h10);
		// The write sets bits 6 to 8 too; the legacy read hides them.
		wr(64'h600501ce, 2'h0);
		chk(nat_rdata, 64'h600501de);
		leg(11'h002);
		chk(leg_rdata, 64'h6005001e);
		chk(ext_int_enable, 1'b0);
		chk(protected_mode, 1'b0);
		leg(11'h001);
		chk(intercept_fault, 1'b1);
		leg(11'h004);
		chk(coprocessor_unavailable_fault, 1'b1);
		leg(11'h010);
		chk({intercept_fault, coprocessor_unavailable_fault}, 2'h1);
		leg(11'h080);
		chk(sys_flag_trap, 1'b1);
		chk(legacy_flags_word, 64'h202);
		@(negedge ref_clk);
		chk(ext_int_enable, 1'b1);
		leg(11'h200);
		chk(intercept_fault, 1'b1);
		cur_priv = 2'h3;
		leg(11'h400);
		chk(port_bitmap_consult, 1'b1);
		leg(11'h040);
		chk(sys_flag_trap, 1'b0);
		chk(legacy_flags_word, 64'h202);
		cur_priv = 2'h0;
		leg(11'h400);
		chk(port_bitmap_consult, 1'b0);
		flags_wdata = 32'h00240200;
		leg(11'h100);
		chk(legacy_flags_word[21], 1'b1);
		native_align_check = 1'b0;
		eff_priv = 2'h3;
		leg(11'h020);
		chk(align_check_fault, 1'b1);
		eff_priv = 2'h0;
		leg(11'h020);
		chk(align_check_fault, 1'b0);
		native_align_check = 1'b1;
		wr(64'h5, 2'h0);
		@(negedge ref_clk);
		chk(protected_mode, 1'b1);
		leg(11'h010);
		chk({intercept_fault, coprocessor_unavailable_fault}, 2'h2);
		leg(11'h008);
		chk(coprocessor_unavailable_fault, 1'b1);
		leg(11'h020);
		chk(align_check_fault, 1'b1);
		chk(fp_error_out, 1'b0);
		summarize;
	end
endmodule // lcflg_regs_bench
`default_nettype wire
